// ### eeprom_dev.sv
// serial eeprom slave: control decode, read paths, half-array protect
//
// Functional notes
// - wp high refuses writes to 40h-7Fh
// - master starts reads like writes, dir 1
// - pointer holds last accessed location plus one
// - read control byte: ack, send one byte
// - nack then stop ends a read
// - dummy write loads pointer, restart abandons write
// - read after restart returns loaded address
// - master ack requests next consecutive byte
// - pointer advances after every byte access
// - match code 1010, ignore block bits
// - no acknowledge while programming runs
// - release data line after master nack
`timescale 1ns/1ps
module eeprom_dev
   import eeprom_pkg::*;
#(
   parameter int WRITE_CYCLES_P = WRITE_CYCLES
)
(
   input  wire logic     core_clk,
   input  wire logic     rst_n,
   eeprom_link_if.device link,
   input  wire logic     wp,
   output logic          busy
);

   // ---------------------------------------------------------------
   // pin synchronisers
   // ---------------------------------------------------------------
   logic [2:0] pin_raw;
   logic [2:0] s1_r;
   logic [2:0] s2_r;
   logic [2:0] s3_r;
   logic [2:0] filt_r;

   assign pin_raw = {wp, link.sda, link.scl};

   // three flops per pin, value taken once stages two and three agree
   genvar g;
   generate
      for (g = 0; g < 3; g++) begin : g_sync
         always_ff @(posedge core_clk or negedge rst_n) begin
            if (!rst_n) begin
               s1_r[g]   <= 1'h1;
               s2_r[g]   <= 1'h1;
               s3_r[g]   <= 1'h1;
               filt_r[g] <= 1'h1;
            end else begin
               s1_r[g] <= pin_raw[g];
               s2_r[g] <= s1_r[g];
               s3_r[g] <= s2_r[g];
               if (s2_r[g] == s3_r[g]) begin
                  filt_r[g] <= s3_r[g];
               end
            end
         end
      end
   endgenerate

   logic scl_now;
   logic sda_now;
   logic wp_now;
   logic scl_q_r;
   logic sda_q_r;

   assign scl_now = filt_r[0];
   assign sda_now = filt_r[1];
   assign wp_now  = filt_r[2];

   // previous filtered levels for edge detection
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         scl_q_r <= 1'h1;
         sda_q_r <= 1'h1;
      end else begin
         scl_q_r <= scl_now;
         sda_q_r <= sda_now;
      end
   end

   // ---------------------------------------------------------------
   // bus conditions
   // ---------------------------------------------------------------
   logic scl_rise;
   logic scl_fall;
   logic start_ev;
   logic stop_ev;

   assign scl_rise = scl_now && !scl_q_r;
   assign scl_fall = !scl_now && scl_q_r;
   // data edges while clock stays high
   assign start_ev = scl_now && scl_q_r && sda_q_r && !sda_now;
   assign stop_ev  = scl_now && scl_q_r && !sda_q_r && sda_now;

   // ---------------------------------------------------------------
   // state and storage
   // ---------------------------------------------------------------
   dev_state_t        state_r;
   dev_state_t        after_r;    // state entered after the ack slot
   logic [3:0]        bit_r;
   logic [7:0]        sh_r;
   logic [ADDR_W-1:0] ptr_r;
   logic              oe_r;       // pulls data line low
   logic              mack_r;     // master acknowledged last byte
   logic              wrote_r;    // array changed since last stop
   logic [BUSY_W-1:0] busy_cnt_r;
   logic [7:0]        mem_r [MEM_DEPTH];

   logic              byte_done;
   logic              ctrl_hit;
   logic              wr_prot;
   logic              mem_we;
   logic              load_rd;
   logic [7:0]        rd_byte;

   assign byte_done = (bit_r == 4'h8);
   assign rd_byte   = mem_r[ptr_r];
   assign busy      = (busy_cnt_r != '0);

   // only the type code counts, block bits are don't care
   assign ctrl_hit = (sh_r[7:4] == CTRL_CODE);

   // upper half locked while protect pin is high
   assign wr_prot = wp_now && (ptr_r >= PROT_BASE);

   assign mem_we = scl_fall && (state_r == D_WDATA) && byte_done
                   && !wr_prot && !start_ev && !stop_ev;

   // next data byte is fetched after the ack slot of a read control byte
   // or after the master acknowledges a data byte
   assign load_rd = scl_fall && !start_ev && !stop_ev
                    && (((state_r == D_ACK) && (after_r == D_RDATA))
                        || ((state_r == D_MACK) && mack_r));

   // ---------------------------------------------------------------
   // array write port
   // ---------------------------------------------------------------
   // array write, data byte lands at the pointer
   always_ff @(posedge core_clk) begin
      if (mem_we) begin
         mem_r[ptr_r] <= sh_r;
      end
   end

   // ---------------------------------------------------------------
   // programming cycle timer
   // ---------------------------------------------------------------
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         wrote_r <= 1'h0;
      end else if (mem_we) begin
         wrote_r <= 1'h1;
      end else if (stop_ev) begin
         wrote_r <= 1'h0;
      end
   end

   // stop after a write starts the internal cycle
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         busy_cnt_r <= '0;
      end else if (stop_ev && wrote_r) begin
         busy_cnt_r <= BUSY_W'(WRITE_CYCLES_P);
      end else if (busy) begin
         busy_cnt_r <= busy_cnt_r - BUSY_W'(1);
      end
   end

   // ---------------------------------------------------------------
   // protocol engine
   // ---------------------------------------------------------------
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         state_r <= D_IDLE;
         after_r <= D_IDLE;
         bit_r   <= 4'h0;
         sh_r    <= 8'h00;
         ptr_r   <= '0;
         oe_r    <= 1'h0;
         mack_r  <= 1'h0;
      end else if (stop_ev) begin
         state_r <= D_IDLE;
         oe_r    <= 1'h0;
      end else if (start_ev) begin
         // a restart drops any write but keeps the pointer
         state_r <= D_CTRL;
         bit_r   <= 4'h0;
         oe_r    <= 1'h0;
      end else if (load_rd) begin
         // fetch at the pointer, then step it past this byte
         sh_r    <= rd_byte;
         oe_r    <= !rd_byte[7];
         ptr_r   <= ptr_r + 7'h1;
         bit_r   <= 4'h0;
         state_r <= D_RDATA;
      end else begin
         unique case (state_r)
            D_IDLE: begin
               oe_r <= 1'h0;
            end
            D_CTRL, D_ADDR, D_WDATA: begin
               if (scl_rise && !byte_done) begin
                  sh_r  <= {sh_r[6:0], sda_now};
                  bit_r <= bit_r + 4'h1;
               end else if (scl_fall && byte_done) begin
                  bit_r <= 4'h0;
                  if (state_r == D_CTRL) begin
                     // silent while programming, even for reads
                     if (ctrl_hit && !busy) begin
                        oe_r    <= 1'h1;
                        state_r <= D_ACK;
                        after_r <= (sh_r[0] == DIR_READ) ? D_RDATA
                                                         : D_ADDR;
                     end else begin
                        state_r <= D_IDLE;
                     end
                  end else begin
                     if (state_r == D_ADDR) begin
                        ptr_r <= sh_r[ADDR_W-1:0];
                     end else begin
                        ptr_r <= ptr_r + 7'h1;
                     end
                     oe_r    <= 1'h1;
                     state_r <= D_ACK;
                     after_r <= D_WDATA;
                  end
               end
            end
            D_ACK: begin
               // release after the ack slot of a write byte
               if (scl_fall) begin
                  oe_r    <= 1'h0;
                  bit_r   <= 4'h0;
                  state_r <= after_r;
               end
            end
            D_RDATA: begin
               if (scl_fall) begin
                  if (bit_r == 4'h7) begin
                     oe_r    <= 1'h0;  // free line for master ack
                     state_r <= D_MACK;
                  end else begin
                     sh_r  <= {sh_r[6:0], 1'h0};
                     oe_r  <= !sh_r[6];
                     bit_r <= bit_r + 4'h1;
                  end
               end
            end
            D_MACK: begin
               if (scl_rise) begin
                  mack_r <= !sda_now;
               end else if (scl_fall) begin
                  // no ack: stay off the line until stop
                  oe_r    <= 1'h0;
                  state_r <= D_IDLE;
               end
            end
            default: begin
               oe_r    <= 1'h0;
               state_r <= D_IDLE;
            end
         endcase
      end
   end

   // ---------------------------------------------------------------
   // open-drain data pin
   // ---------------------------------------------------------------
   assign link.sda_d_o  = 1'h0;
   assign link.sda_d_oe = oe_r;

endmodule

// ### eeprom_pkg.sv
// shared constants and types for the serial eeprom and its bus master
package eeprom_pkg;

   // ---------------------------------------------------------------
   // array geometry and protection
   // ---------------------------------------------------------------
   localparam int        MEM_DEPTH = 128;
   localparam int        ADDR_W    = 7;
   localparam logic [6:0] PROT_BASE = 7'h40;  // first protected location
   localparam logic [3:0] CTRL_CODE = 4'ha;   // device type code 1010
   localparam logic       DIR_READ  = 1'h1;
   localparam logic [2:0] BLK_SEL   = 3'h0;   // block bits, ignored by slave

   // ---------------------------------------------------------------
   // timing
   // ---------------------------------------------------------------
   localparam int CLK_FREQ_KHZ  = 250000;
   localparam int SCL_FREQ_KHZ  = 400;
   localparam int QTR_CYCLES    = CLK_FREQ_KHZ / (4 * SCL_FREQ_KHZ);
   localparam int QTR_W         = 8;
   localparam int WRITE_TIME_US = 3000;
   localparam int WRITE_CYCLES  = WRITE_TIME_US * (CLK_FREQ_KHZ / 1000);
   localparam int BUSY_W        = 20;

   // ---------------------------------------------------------------
   // host command codes
   // ---------------------------------------------------------------
   localparam logic [1:0] OP_WRITE = 2'h0;  // byte write
   localparam logic [1:0] OP_CUR   = 2'h1;  // current address read
   localparam logic [1:0] OP_RAND  = 2'h2;  // random read

   // ---------------------------------------------------------------
   // state encodings
   // ---------------------------------------------------------------
   typedef enum logic [2:0] {
      D_IDLE  = 3'h0,
      D_CTRL  = 3'h1,
      D_ADDR  = 3'h2,
      D_WDATA = 3'h3,
      D_ACK   = 3'h4,
      D_RDATA = 3'h5,
      D_MACK  = 3'h6
   } dev_state_t;

   typedef enum logic [3:0] {
      M_IDLE   = 4'h0,
      M_START  = 4'h1,
      M_CTRLW  = 4'h2,
      M_ADDR   = 4'h3,
      M_WDATA  = 4'h4,
      M_RSTART = 4'h5,
      M_CTRLR  = 4'h6,
      M_READ   = 4'h7,
      M_STOP   = 4'h8
   } mst_state_t;

   // control byte as sent by the master
   function automatic logic [7:0] ctrl_byte(input logic rd);
      return {CTRL_CODE, BLK_SEL, rd};
   endfunction

endpackage

// ### eeprom_link_if.sv
// two-wire link between the eeprom and its bus master
`timescale 1ns/1ps
interface eeprom_link_if;
   logic scl_o;     // master clock drive value
   logic scl_oe;    // master pulls clock
   logic sda_m_o;   // master data drive value
   logic sda_m_oe;  // master pulls data
   logic sda_d_o;   // eeprom data drive value
   logic sda_d_oe;  // eeprom pulls data
   logic scl;       // resolved clock wire
   logic sda;       // resolved data wire

   // open-drain wires with pull-ups
   assign scl = !(scl_oe && !scl_o);
   assign sda = !((sda_m_oe && !sda_m_o) || (sda_d_oe && !sda_d_o));

   modport device (
      input  scl,
      input  sda,
      output sda_d_o,
      output sda_d_oe
   );

   modport host (
      output scl_o,
      output scl_oe,
      output sda_m_o,
      output sda_m_oe,
      input  sda
   );
endinterface

// ### eeprom_host.sv
// two-wire bus master issuing writes and the three read kinds
`timescale 1ns/1ps
module eeprom_host
   import eeprom_pkg::*;
(
   input  wire logic       core_clk,
   input  wire logic       rst_n,
   eeprom_link_if.host     link,
   input  wire logic       cmd_valid,
   output logic            cmd_ready,
   input  wire logic [1:0] cmd_op,
   input  wire logic [6:0] cmd_addr,
   input  wire logic [7:0] cmd_wdata,
   input  wire logic [7:0] cmd_len,
   output logic            rsp_valid,
   output logic [7:0]      rsp_data,
   output logic            rsp_nack,
   output logic            rsp_done
);

   // ---------------------------------------------------------------
   // quarter-bit tick divider
   // ---------------------------------------------------------------
   logic [QTR_W-1:0] qcnt_r;
   logic             tick;

   assign tick = (qcnt_r == QTR_W'(QTR_CYCLES - 1));

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         qcnt_r <= '0;
      end else if (tick) begin
         qcnt_r <= '0;
      end else begin
         qcnt_r <= qcnt_r + QTR_W'(1);
      end
   end

   // ---------------------------------------------------------------
   // data line synchroniser
   // ---------------------------------------------------------------
   logic [2:0] sda_s_r;
   logic       sda_in_r;

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         sda_s_r  <= 3'h7;
         sda_in_r <= 1'h1;
      end else begin
         sda_s_r <= {sda_s_r[1:0], link.sda};
         if (sda_s_r[1] == sda_s_r[2]) begin
            sda_in_r <= sda_s_r[2];
         end
      end
   end

   // ---------------------------------------------------------------
   // sequencer
   // ---------------------------------------------------------------
   mst_state_t st_r;
   logic [1:0] ph_r;
   logic [3:0] bit_r;
   logic [7:0] sh_r;
   logic [1:0] op_r;
   logic [6:0] addr_r;
   logic [7:0] wdata_r;
   logic [7:0] left_r;
   logic       ack_r;
   logic       scl_low_r;
   logic       sda_low_r;
   logic       is_rx;

   assign cmd_ready = (st_r == M_IDLE);
   assign is_rx     = (st_r == M_READ);

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         st_r      <= M_IDLE;
         ph_r      <= 2'h0;
         bit_r     <= 4'h0;
         sh_r      <= 8'h00;
         op_r      <= OP_WRITE;
         addr_r    <= 7'h00;
         wdata_r   <= 8'h00;
         left_r    <= 8'h00;
         ack_r     <= 1'h0;
         scl_low_r <= 1'h0;
         sda_low_r <= 1'h0;
         rsp_valid <= 1'h0;
         rsp_data  <= 8'h00;
         rsp_nack  <= 1'h0;
         rsp_done  <= 1'h0;
      end else begin
         rsp_valid <= 1'h0;
         rsp_nack  <= 1'h0;
         rsp_done  <= 1'h0;
         if (st_r == M_IDLE) begin
            if (cmd_valid) begin
               op_r    <= cmd_op;
               addr_r  <= cmd_addr;
               wdata_r <= cmd_wdata;
               left_r  <= (cmd_len == 8'h00) ? 8'h01 : cmd_len;
               ph_r    <= 2'h0;
               st_r    <= M_START;
            end
         end else if (tick) begin
            ph_r <= ph_r + 2'h1;
            unique case (st_r)
               M_START, M_RSTART: begin
                  // data falls while clock is high
                  unique case (ph_r)
                     2'h0: sda_low_r <= 1'h0;
                     2'h1: scl_low_r <= 1'h0;
                     2'h2: sda_low_r <= 1'h1;
                     2'h3: begin
                        scl_low_r <= 1'h1;
                        bit_r     <= 4'h0;
                        // current reads and the restart of a random read open with direction bit set
                        if (st_r == M_RSTART || op_r == OP_CUR) begin
                           sh_r <= ctrl_byte(DIR_READ);
                           st_r <= M_CTRLR;
                        end else begin
                           sh_r <= ctrl_byte(1'h0);
                           st_r <= M_CTRLW;
                        end
                     end
                  endcase
               end
               M_STOP: begin
                  // data rises while clock is high
                  unique case (ph_r)
                     2'h0: sda_low_r <= 1'h1;
                     2'h1: scl_low_r <= 1'h0;
                     2'h2: sda_low_r <= 1'h0;
                     2'h3: begin
                        rsp_done <= 1'h1;
                        st_r     <= M_IDLE;
                     end
                  endcase
               end
               default: begin
                  unique case (ph_r)
                     2'h0: begin
                        if (bit_r != 4'h8) begin
                           sda_low_r <= is_rx ? 1'h0 : !sh_r[7];
                        end else begin
                           // ack more bytes, nack the last one
                           sda_low_r <= is_rx && (left_r > 8'h01);
                        end
                     end
                     2'h1: scl_low_r <= 1'h0;
                     2'h2: begin
                        if (bit_r != 4'h8) begin
                           sh_r <= {sh_r[6:0], sda_in_r};
                        end else begin
                           ack_r <= !sda_in_r;
                        end
                     end
                     2'h3: begin
                        scl_low_r <= 1'h1;
                        if (bit_r != 4'h8) begin
                           bit_r <= bit_r + 4'h1;
                        end else begin
                           bit_r <= 4'h0;
                           if (!is_rx && !ack_r) begin
                              rsp_nack <= 1'h1;
                              st_r     <= M_STOP;
                           end else begin
                              unique case (st_r)
                                 M_CTRLW: begin
                                    sh_r <= {1'h0, addr_r};
                                    st_r <= M_ADDR;
                                 end
                                 M_ADDR: begin
                                    // random read restarts after address
                                    sh_r <= wdata_r;
                                    st_r <= (op_r == OP_WRITE) ? M_WDATA
                                                               : M_RSTART;
                                 end
                                 M_CTRLR: st_r <= M_READ;
                                 M_READ: begin
                                    rsp_valid <= 1'h1;
                                    rsp_data  <= sh_r;
                                    left_r    <= left_r - 8'h01;
                                    st_r <= (left_r > 8'h01) ? M_READ
                                                             : M_STOP;
                                 end
                                 default: st_r <= M_STOP;
                              endcase
                           end
                        end
                     end
                  endcase
               end
            endcase
         end
      end
   end

   // ---------------------------------------------------------------
   // open-drain pins
   // ---------------------------------------------------------------
   assign link.scl_o    = 1'h0;
   assign link.scl_oe   = scl_low_r;
   assign link.sda_m_o  = 1'h0;
   assign link.sda_m_oe = sda_low_r;

endmodule

// ### eeprom_link_props.sv
// assertions on the two-wire link between the eeprom and its master
`timescale 1ns/1ps
module eeprom_link_props #(
   parameter int WRITE_CYCLES_P = 50
)
(
   input wire logic core_clk,
   input wire logic rst_n,
   input wire logic scl_o,
   input wire logic scl_oe,
   input wire logic sda_m_o,
   input wire logic sda_m_oe,
   input wire logic sda_d_o,
   input wire logic sda_d_oe,
   input wire logic scl,
   input wire logic sda,
   input wire logic busy
);
   int busy_cnt;

   // counts the cycles of one programming interval
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n)
         busy_cnt <= 0;
      else if (busy)
         busy_cnt <= busy_cnt + 1;
      else
         busy_cnt <= 0;
   end

   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (!rst_n);

   // ----------------------------------------------------------
   // bus conditions
   // ----------------------------------------------------------
   sequence s_start;
      scl && $fell(sda);
   endsequence
   sequence s_stop;
      scl && $rose(sda);
   endsequence

   a_busy_no_ack: assert property (busy |-> !sda_d_oe)
      else $error("eeprom pulled sda while programming");
   a_busy_length: assert property (
      $fell(busy) |-> busy_cnt == WRITE_CYCLES_P)
      else $error("programming interval has wrong length");
   a_busy_at_stop: assert property (
      $rose(busy) |-> scl && sda && !sda_d_oe)
      else $error("programming began outside an idle bus");
   a_oe_scl_low: assert property (
      $changed(sda_d_oe) |-> !scl)
      else $error("eeprom changed sda while scl high");
   a_oe_after_fall: assert property (
      $changed(sda_d_oe) |-> !$past(scl, 2) && $past(scl, 8))
      else $error("eeprom sda change not tied to scl fall");
   a_drive_held: assert property (
      $rose(sda_d_oe) |-> sda_d_oe [*8])
      else $error("eeprom drive too short");
   a_drive_low: assert property (sda_d_oe |-> !sda_d_o)
      else $error("eeprom drives a high level");
   a_stop_release: assert property (
      s_stop |=> !sda_d_oe [*4])
      else $error("eeprom pulled sda after stop");
   a_start_master: assert property (s_start |-> sda_m_oe)
      else $error("start not made by the master");
   a_host_pulls_low: assert property (
      (scl_oe || sda_m_oe) |-> !(scl_oe && scl_o) && !(sda_m_oe && sda_m_o))
      else $error("master drives a high level");
endmodule

// ### i2c_eeprom_read_and_write_protect_tb_top.sv
// testbench: master and eeprom joined over the two-wire link
`timescale 1ns/1ps
module i2c_eeprom_read_and_write_protect_tb_top
   import eeprom_pkg::*;
   ;
   localparam int BUSY_CYC = 6500;
   logic       core_clk;
   logic       rst_n;
   logic       wp;
   logic       busy;
   logic       cmd_valid;
   logic       cmd_ready;
   logic [1:0] cmd_op;
   logic [6:0] cmd_addr;
   logic [7:0] cmd_wdata;
   logic [7:0] cmd_len;
   logic       rsp_valid;
   logic [7:0] rsp_data;
   logic       rsp_nack;
   logic       rsp_done;
   logic [15:0] lfsr_r;
   logic [7:0] r0, r1, r2;
   logic [8:0] exp_q[$];
   logic [8:0] e;
   int         n_mismatch = 0;
   int         checked = 0;

   eeprom_link_if link();
   eeprom_dev #(.WRITE_CYCLES_P(BUSY_CYC)) u_eeprom_dev(
      .core_clk(core_clk), .rst_n(rst_n), .link(link), .wp(wp),
      .busy(busy));
   eeprom_host u_eeprom_host(
      .core_clk(core_clk), .rst_n(rst_n), .link(link),
      .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_op(cmd_op),
      .cmd_addr(cmd_addr), .cmd_wdata(cmd_wdata), .cmd_len(cmd_len),
      .rsp_valid(rsp_valid), .rsp_data(rsp_data), .rsp_nack(rsp_nack),
      .rsp_done(rsp_done));
   eeprom_link_props #(.WRITE_CYCLES_P(BUSY_CYC)) u_eeprom_link_props(
      .core_clk(core_clk), .rst_n(rst_n), .scl_o(link.scl_o),
      .scl_oe(link.scl_oe), .sda_m_o(link.sda_m_o),
      .sda_m_oe(link.sda_m_oe), .sda_d_o(link.sda_d_o),
      .sda_d_oe(link.sda_d_oe), .scl(link.scl), .sda(link.sda),
      .busy(busy));

   function automatic logic [15:0] lfsr_step(input logic [15:0] v);
      return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
   endfunction

   task automatic chk_byte(input string w, input logic [7:0] x, g);
      checked++;
      if (g !== x) begin
         n_mismatch++;
         $display("wrong value %s expected %h seen %h", w, x, g);
      end
   endtask

   task automatic chk_bit(input string w, input logic x, g);
      checked++;
      if (g !== x) begin
         n_mismatch++;
         $display("wrong value %s expected %b seen %b", w, x, g);
      end
   endtask

   task automatic test_done;
      $display("checked %0d mismatches %0d", checked, n_mismatch);
      if (n_mismatch == 0 && checked > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask

   // issues one command and waits for its completion
   task automatic run(input logic [1:0] op, input logic [6:0] a,
                      input logic [7:0] d, input logic [7:0] n);
      int i;
      @(negedge core_clk);
      cmd_valid = 1'b1;
      cmd_op = op;
      cmd_addr = a;
      cmd_wdata = d;
      cmd_len = n;
      while (cmd_ready !== 1'b1) @(negedge core_clk);
      @(negedge core_clk);
      cmd_valid = 1'b0;
      chk_bit("ready taken", 1'b0, cmd_ready);
      for (i = 0; i < 40000 && rsp_done !== 1'b1; i++) @(negedge core_clk);
      chk_bit("done", 1'b1, rsp_done);
      repeat (8) @(negedge core_clk);
      chk_bit("ready idle", 1'b1, cmd_ready);
   endtask

   task automatic wait_idle;
      int i;
      for (i = 0; i < BUSY_CYC + 100 && busy !== 1'b0; i++)
         @(negedge core_clk);
      chk_bit("busy end", 1'b0, busy);
   endtask

   // clock
   initial begin
      core_clk = 1'b0;
      forever #2 core_clk = ~core_clk;
   end

   // result watcher: takes the oldest note for each answer
   always @(negedge core_clk) begin
      if (rsp_valid === 1'b1 || rsp_nack === 1'b1) begin
         e = (exp_q.size() > 0) ? exp_q.pop_front() : 9'h1ff;
         chk_bit("nack", e[8], rsp_nack);
         if (!e[8]) chk_byte("read data", e[7:0], rsp_data);
      end
   end

   // watchdog
   initial begin
      repeat (125000) @(posedge core_clk);
      n_mismatch++;
      test_done();
   end

   // main sequence
   initial begin
      rst_n = 1'b0;
      wp = 1'b0;
      cmd_valid = 1'b0;
      cmd_op = OP_WRITE;
      cmd_addr = 7'h00;
      cmd_wdata = 8'h00;
      cmd_len = 8'h00;
      lfsr_r = 16'hd16a;
      lfsr_r = lfsr_step(lfsr_r);
      r0 = lfsr_r[7:0];
      lfsr_r = lfsr_step(lfsr_r);
      r1 = lfsr_r[7:0];
      lfsr_r = lfsr_step(lfsr_r);
      r2 = ~r1 ^ lfsr_r[7:0] ^ r1;
      repeat (3) @(negedge core_clk);
      rst_n = 1'b1;
      run(OP_WRITE, 7'h7f, r1, 8'h00);
      chk_bit("busy", 1'b1, busy);
      exp_q.push_back(9'h100);
      run(OP_CUR, 7'h00, 8'h00, 8'h01);
      wait_idle();
      $display("test 1 done: write and read while busy");
      wp = 1'b1;
      run(OP_WRITE, 7'h00, r0, 8'h00);
      chk_bit("busy low half", 1'b1, busy);
      wait_idle();
      run(OP_WRITE, 7'h7f, r2, 8'h00);
      chk_bit("busy high half", 1'b0, busy);
      $display("test 2 done: writes under protection");
      exp_q.push_back({1'b0, r0});
      run(OP_CUR, 7'h00, 8'h00, 8'h01);
      $display("test 3 done: current address read");
      exp_q.push_back({1'b0, r1});
      exp_q.push_back({1'b0, r0});
      run(OP_RAND, 7'h7f, 8'h00, 8'h02);
      chk_bit("all answered", 1'b1, 1'(exp_q.size() == 0));
      $display("test 4 done: random sequential read");
      test_done();
   end
endmodule
